// [design/input_function_mapper.sv]
// input function mapper: pin filtering, polarity, mapping, forcing, axi4-lite registers
`timescale 1ns/10ps

module input_function_mapper #(
  parameter int tick_cycles = input_mapper_pkg::filter_unit_cycles
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] input_pin_channel,
  input wire logic ninth_input_channel,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [39:0] function_state,
  output logic servo_on_request,
  output logic forward_permit,
  output logic reverse_permit
);
  localparam logic [15:0] tick_last = 16'(tick_cycles - 1);
  localparam logic [2:0] kind_none = 3'h0;
  localparam logic [2:0] kind_select = 3'h1;
  localparam logic [2:0] kind_filter = 3'h2;
  localparam logic [2:0] kind_mask = 3'h3;
  localparam logic [2:0] kind_inhibit = 3'h4;
  localparam logic [2:0] kind_forced = 3'h5;
  localparam logic [2:0] kind_status = 3'h6;

  function automatic logic [2:0] reg_kind(input logic [31:0] a);
    logic [5:0] w;
    w = a[7:2];
    reg_kind = kind_none;
    if (a[31:8] == 24'h000000) begin
      if (w < input_mapper_pkg::word_select + 6'(input_mapper_pkg::num_channels))
        reg_kind = kind_select;
      else if (w >= input_mapper_pkg::word_filter &&
               w < input_mapper_pkg::word_filter + 6'(input_mapper_pkg::num_filters))
        reg_kind = kind_filter;
      else if (w >= input_mapper_pkg::word_mask &&
               w < input_mapper_pkg::word_mask + 6'(input_mapper_pkg::num_masks))
        reg_kind = kind_mask;
      else if (w == input_mapper_pkg::word_inhibit)
        reg_kind = kind_inhibit;
      else if (w == input_mapper_pkg::word_forced)
        reg_kind = kind_forced;
      else if (w >= input_mapper_pkg::word_inputs && w <= input_mapper_pkg::word_func_high)
        reg_kind = kind_status;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers and bus state
  input_mapper_pkg::select_t sel [9];
  input_mapper_pkg::filter_t filt [8];
  input_mapper_pkg::mask_t mask [8];
  logic [1:0] inhibit_ignore;
  logic forced_enable;
  input_mapper_pkg::select_t next_sel [9];
  input_mapper_pkg::filter_t next_filt [8];
  input_mapper_pkg::mask_t next_mask [8];
  logic [1:0] next_inhibit_ignore;
  logic next_forced_enable;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [31:0] aw_addr_q, w_data_q, next_aw_addr_q, next_w_data_q;
  logic [3:0] w_strb_q, next_w_strb_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // filter and output state
  logic [8:0] sync1, sync2, filtered, next_filtered;
  logic [9:0] cnt [9];
  logic [9:0] next_cnt [9];
  logic [15:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic [39:0] next_function_state, planned;
  logic next_servo_on, next_forward, next_reverse;

  // handshakes stall while the clock enable is low
  assign awready = ce & ~aw_held;
  assign wready = ce & ~w_held;
  assign arready = ce & ~rvalid;

  ////////////////////////////////////////////////////////////////////////////////
  // bus and register file
  always_comb begin
    logic [2:0] wk;
    logic [2:0] rk;
    logic [3:0] wi;
    logic [3:0] ri;
    logic [31:0] m;
    wk = reg_kind(aw_addr_q);
    rk = reg_kind(araddr);
    wi = aw_addr_q[5:2];
    ri = araddr[5:2];
    m = 32'h00000000;
    next_sel = sel;
    next_filt = filt;
    next_mask = mask;
    next_inhibit_ignore = inhibit_ignore;
    next_forced_enable = forced_enable;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wk == kind_none) ? input_mapper_pkg::resp_slverr
                                     : input_mapper_pkg::resp_okay;
      // out-of-range values are dropped so the map never points past the function set
      case (wk)
        kind_select: begin
          m = merge({{25{sel[wi][6]}}, sel[wi]}, w_data_q, w_strb_q);
          if ($signed(m) >= input_mapper_pkg::select_min &&
              $signed(m) <= input_mapper_pkg::select_max)
            next_sel[wi] = m[6:0];
        end
        kind_filter: begin
          m = merge({22'h000000, filt[wi[2:0]]}, w_data_q, w_strb_q);
          if (m >= 32'(input_mapper_pkg::filter_min) && m <= 32'(input_mapper_pkg::filter_max))
            next_filt[wi[2:0]] = m[9:0];
        end
        kind_mask: begin
          m = merge({27'h0000000, mask[wi[2:0]]}, w_data_q, w_strb_q);
          next_mask[wi[2:0]] = m[4:0];
        end
        kind_inhibit: begin
          m = merge({30'h00000000, inhibit_ignore}, w_data_q, w_strb_q);
          next_inhibit_ignore = m[1:0];
        end
        kind_forced: begin
          m = merge({31'h00000000, forced_enable}, w_data_q, w_strb_q);
          next_forced_enable = m[0];
        end
        default: begin
        end
      endcase
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = (rk == kind_none) ? input_mapper_pkg::resp_slverr
                                     : input_mapper_pkg::resp_okay;
      case (rk)
        kind_select: next_rdata = {{25{sel[ri][6]}}, sel[ri]};
        kind_filter: next_rdata = {22'h000000, filt[ri[2:0]]};
        kind_mask: next_rdata = {27'h0000000, mask[ri[2:0]]};
        kind_inhibit: next_rdata = {30'h00000000, inhibit_ignore};
        kind_forced: next_rdata = {31'h00000000, forced_enable};
        kind_status: begin
          if (araddr[7:2] == input_mapper_pkg::word_inputs)
            next_rdata = {23'h000000, filtered};
          else if (araddr[7:2] == input_mapper_pkg::word_func_low)
            next_rdata = function_state[31:0];
          else if (araddr[7:2] == input_mapper_pkg::word_func_high)
            next_rdata = {21'h000000, reverse_permit, forward_permit, servo_on_request,
                          function_state[39:32]};
          else
            next_rdata = 32'h00000000;
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 9; i++) begin
        sel[i] <= input_mapper_pkg::select_reset[i];
      end
      for (int i = 0; i < 8; i++) begin
        filt[i] <= input_mapper_pkg::filter_reset;
        mask[i] <= input_mapper_pkg::mask_reset;
      end
      inhibit_ignore <= input_mapper_pkg::inhibit_reset;
      forced_enable <= input_mapper_pkg::forced_reset;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
    end else if (ce) begin
      sel <= next_sel;
      filt <= next_filt;
      mask <= next_mask;
      inhibit_ignore <= next_inhibit_ignore;
      forced_enable <= next_forced_enable;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input filters, counted in 0.1 ms ticks
  assign tick = (tick_cnt == tick_last);

  // the first tick after a change may be partial, so the delay is up to one tick short
  always_comb begin
    logic [9:0] lim;
    lim = 10'h000;
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_filtered = filtered;
    next_cnt = cnt;
    for (int i = 0; i < 9; i++) begin
      lim = filt[(i < 8) ? i : 0];
      if (sync2[i] == filtered[i]) begin
        next_cnt[i] = 10'h000;
      end else if (tick) begin
        if (cnt[i] + 10'h001 >= lim) begin
          next_filtered[i] = sync2[i];
          next_cnt[i] = 10'h000;
        end else begin
          next_cnt[i] = cnt[i] + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      filtered <= 9'h000;
      tick_cnt <= 16'h0000;
      for (int i = 0; i < 9; i++) begin
        cnt[i] <= 10'h000;
      end
    end else if (ce) begin
      sync1 <= {ninth_input_channel, input_pin_channel};
      sync2 <= sync1;
      filtered <= next_filtered;
      tick_cnt <= next_tick_cnt;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // function mapping and drive outputs
  always_comb begin
    logic [6:0] mag;
    mag = 7'h00;
    next_function_state = 40'h0000000000;
    planned = 40'h0000000000;
    for (int i = 0; i < 9; i++) begin
      mag = sel[i][6] ? 7'(-sel[i]) : sel[i];
      if (mag != 7'h00) begin
        planned[mag[5:0]] = 1'b1;
        next_function_state[mag[5:0]] = next_function_state[mag[5:0]] |
                                        (filtered[i] ^ sel[i][6]);
      end
    end
    for (int w = 0; w < input_mapper_pkg::num_masks; w++) begin
      next_function_state[w*input_mapper_pkg::mask_bits +: input_mapper_pkg::mask_bits] =
        next_function_state[w*input_mapper_pkg::mask_bits +: input_mapper_pkg::mask_bits] |
        mask[w];
    end
    next_servo_on = next_function_state[input_mapper_pkg::fn_servo_on] | forced_enable;
    next_forward = inhibit_ignore[0] |
                   next_function_state[input_mapper_pkg::fn_forward_limit];
    next_reverse = inhibit_ignore[1] |
                   next_function_state[input_mapper_pkg::fn_reverse_limit];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      function_state <= 40'h0000000000;
      servo_on_request <= 1'b0;
      forward_permit <= 1'b0;
      reverse_permit <= 1'b0;
    end else if (ce) begin
      function_state <= next_function_state;
      servo_on_request <= next_servo_on;
      forward_permit <= next_forward;
      reverse_permit <= next_reverse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  chk_polarity_invert: assert property (@(posedge clk) disable iff (!rstn)
    ce && sel[1] == 7'h7F && !filtered[1] |=> function_state[1])
    else $error("negative selector did not invert the input");
  chk_or_merge: assert property (@(posedge clk) disable iff (!rstn)
    ce && sel[0] == 7'h01 && (sel[1] == 7'h01 || sel[1] == 7'h7F) &&
    (filtered[0] | (filtered[1] ^ sel[1][6])) |=> function_state[1])
    else $error("shared function not ORed");
  chk_unplanned_off: assert property (@(posedge clk) disable iff (!rstn)
    ce && !planned[2] && !mask[0][2] |=> !function_state[2])
    else $error("unplanned function not off");
  chk_mask_forces: assert property (@(posedge clk) disable iff (!rstn)
    ce && mask[1][2] |=> function_state[7])
    else $error("force mask bit did not force its function on");
  chk_filter_tick: assert property (@(posedge clk) disable iff (!rstn)
    ce && !tick |=> $stable(filtered))
    else $error("filtered input moved between ticks");
  chk_filter_glitch: assert property (@(posedge clk) disable iff (!rstn)
    ce && sync2[8] == filtered[8] |=> filtered[8] == $past(filtered[8]) && cnt[8] == 10'h000)
    else $error("filter passed a level that was not pending");
  chk_limit_use: assert property (@(posedge clk) disable iff (!rstn)
    ce && inhibit_ignore == 2'h0 |=> forward_permit == function_state[3] &&
                                     reverse_permit == function_state[4])
    else $error("used limit does not follow its function");
  chk_ignore_permit: assert property (@(posedge clk) disable iff (!rstn)
    ce && inhibit_ignore[1] |=> reverse_permit)
    else $error("ignored reverse limit blocked motion");
  chk_forced_servo: assert property (@(posedge clk) disable iff (!rstn)
    ce && forced_enable |=> servo_on_request)
    else $error("forced enable did not assert servo on");
endmodule

// [design/input_mapper_pkg.sv]
// constants, register map and types for the input function mapper
package input_mapper_pkg;
  localparam int num_channels = 9;
  localparam int num_filters = 8;
  localparam int num_masks = 8;
  localparam int mask_bits = 5;
  localparam int num_functions = 40;

  typedef logic signed [6:0] select_t;
  typedef logic [9:0] filter_t;
  typedef logic [4:0] mask_t;

  // selector range, sign gives polarity
  localparam int select_min = -37;
  localparam int select_max = 37;
  // filter time in units of 0.1 ms
  localparam filter_t filter_min = 10'h001;
  localparam filter_t filter_max = 10'h3E8;

  // reset values, channel one in the lowest slot; ninth channel starts unmapped
  localparam logic [8:0][6:0] select_reset = {7'h00, 7'h00, 7'h00, 7'h00, 7'h14,
                                             7'h04, 7'h03, 7'h02, 7'h01};
  localparam filter_t filter_reset = 10'h014;
  localparam mask_t mask_reset = 5'h00;
  localparam logic [1:0] inhibit_reset = 2'h3;
  localparam logic forced_reset = 1'b0;

  // function numbers with a meaning of their own inside the block
  localparam int fn_servo_on = 1;
  localparam int fn_forward_limit = 3;
  localparam int fn_reverse_limit = 4;

  // register word offsets (byte address is four times the word)
  localparam logic [5:0] word_select = 6'h00;
  localparam logic [5:0] word_filter = 6'h10;
  localparam logic [5:0] word_mask = 6'h20;
  localparam logic [5:0] word_inhibit = 6'h30;
  localparam logic [5:0] word_forced = 6'h31;
  localparam logic [5:0] word_inputs = 6'h34;
  localparam logic [5:0] word_func_low = 6'h35;
  localparam logic [5:0] word_func_high = 6'h36;

  // filter time base
  localparam int clk_period_ns = 4;
  localparam int filter_unit_ns = 100000;
  localparam int filter_unit_cycles = (filter_unit_ns + clk_period_ns - 1) / clk_period_ns;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// [test/switch_bank.sv]
// far-side model: bank of switches wired to the nine input pins
`timescale 1ns/10ps
module switch_bank (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [8:0] level,
  input wire logic chatter,
  output logic [7:0] pins,
  output logic ninth
);
  logic toggle;
  logic next_toggle;

  ////////////////////////////////////////////////////////////////////////////
  // a bouncing contact flips every cycle, so no level ever settles
  always_comb begin
    next_toggle = chatter ? !toggle : 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toggle <= 1'b0;
    end else begin
      toggle <= next_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit contacts are normally closed: closed reads 1 and permits motion
  assign {ninth, pins} = level ^ {9{toggle}};
endmodule

// [test/test_input_function_mapper.sv]
// self-checking bench for the input function mapper
`timescale 1ns/10ps
module test_input_function_mapper;
  localparam logic [1:0] ok = input_mapper_pkg::resp_okay;
  localparam logic [1:0] err = input_mapper_pkg::resp_slverr;

  typedef struct {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } reg_row_t;

  logic clk, rstn, ce, ninth, chatter;
  logic [7:0] pins;
  logic [8:0] level;
  logic [31:0] awaddr, wdata, araddr, rdata, data;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [39:0] function_state;
  logic servo_on_request, forward_permit, reverse_permit;
  int mismatches, comparisons, i;
  logic [31:0] sel_init [0:8] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h14, 32'h0, 32'h0, 32'h0, 32'h0};
  // out-of-range writes are answered OKAY but must leave the register alone
  reg_row_t rows [0:11] = '{
    '{32'h000, 32'hFFFFFFDB, ok, 32'hFFFFFFDB, ok},
    '{32'h000, 32'h00000026, ok, 32'hFFFFFFDB, ok},
    '{32'h000, 32'h00000001, ok, 32'h00000001, ok},
    '{32'h040, 32'h00000000, ok, 32'h00000014, ok},
    '{32'h040, 32'h000003E8, ok, 32'h000003E8, ok},
    '{32'h040, 32'h000003E9, ok, 32'h000003E8, ok},
    '{32'h080, 32'h0000001F, ok, 32'h0000001F, ok},
    '{32'h080, 32'h00000000, ok, 32'h00000000, ok},
    '{32'h0C4, 32'h00000001, ok, 32'h00000001, ok},
    '{32'h0C4, 32'h00000000, ok, 32'h00000000, ok},
    '{32'h024, 32'h00000005, err, 32'h00000000, err},
    '{32'h100, 32'h00000005, err, 32'h00000000, err}};

  input_function_mapper #(.tick_cycles(4)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .input_pin_channel(pins), .ninth_input_channel(ninth),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .function_state(function_state),
    .servo_on_request(servo_on_request), .forward_permit(forward_permit),
    .reverse_permit(reverse_permit));

  switch_bank far_side (.clk(clk), .rstn(rstn), .level(level), .chatter(chatter),
    .pins(pins), .ninth(ninth));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic reg_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic reg_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic set_reg(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    reg_write(a, d, r);
    check(32'(r), 32'(ok));
  endtask

  task automatic expect_reg(input logic [31:0] a, input logic [31:0] want);
    logic [31:0] d;
    logic [1:0] r;
    reg_read(a, d, r);
    check(d, want);
  endtask

  // filter of one tick plus synchroniser and mapping stay well inside this
  task automatic settle();
    repeat (16) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hF;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, chatter} = '0;
    level = 9'h000;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 9; i++) expect_reg(32'(4 * i), sel_init[i]);
    for (i = 0; i < 8; i++) begin
      expect_reg(32'h40 + 32'(4 * i), 32'h14);
      expect_reg(32'h80 + 32'(4 * i), 32'h0);
    end
    expect_reg(32'hC0, 32'h3);
    expect_reg(32'hC4, 32'h0);
    check(32'({reverse_permit, forward_permit}), 32'h3);
    foreach (rows[k]) begin
      reg_write(rows[k].addr, rows[k].wdata, resp);
      check(32'(resp), 32'(rows[k].bresp));
      reg_read(rows[k].addr, data, resp);
      check(data, rows[k].rdata);
      check(32'(resp), 32'(rows[k].rresp));
    end
    for (i = 0; i < 8; i++) set_reg(32'h40 + 32'(4 * i), 32'h1);
    // channel two inverted onto the same function as channel one
    set_reg(32'h04, 32'hFFFFFFFF);
    settle();
    check(32'(servo_on_request), 32'h1);
    level[1] <= 1'b1;
    settle();
    check(32'(servo_on_request), 32'h0);
    check(32'(function_state[2]), 32'h0);
    level[0] <= 1'b1;
    settle();
    check(32'(servo_on_request), 32'h1);
    set_reg(32'h20, 32'h5);
    level[8] <= 1'b1;
    settle();
    check(32'(function_state[5]), 32'h1);
    set_reg(32'h80, 32'h04);
    set_reg(32'h84, 32'h06);
    settle();
    check(32'(function_state[2]), 32'h1);
    check(32'(function_state[6]), 32'h1);
    check(32'(function_state[7]), 32'h1);
    set_reg(32'h80, 32'h0);
    set_reg(32'h84, 32'h0);
    level[3:2] <= 2'b00;
    for (i = 0; i < 4; i++) begin
      set_reg(32'hC0, 32'(i));
      settle();
      check(32'({reverse_permit, forward_permit}), 32'(i));
    end
    set_reg(32'hC0, 32'h0);
    level[3:2] <= 2'b11;
    settle();
    check(32'({reverse_permit, forward_permit}), 32'h3);
    expect_reg(32'hD0, 32'h0000010F);
    expect_reg(32'hD4, 32'h0000003A);
    expect_reg(32'hD8, 32'h00000700);
    level[1:0] <= 2'b10;
    settle();
    check(32'(servo_on_request), 32'h0);
    set_reg(32'hC4, 32'h1);
    settle();
    check(32'(servo_on_request), 32'h1);
    set_reg(32'hC4, 32'h0);
    // ninth channel must follow the three-tick filter of channel one
    set_reg(32'h40, 32'h3);
    level[8] <= 1'b0;
    repeat (40) @(posedge clk);
    chatter <= 1'b1;
    level[8] <= 1'b1;
    repeat (40) @(posedge clk);
    check(32'(function_state[5]), 32'h0);
    chatter <= 1'b0;
    repeat (9) @(posedge clk);
    check(32'(function_state[5]), 32'h0);
    repeat (20) @(posedge clk);
    check(32'(function_state[5]), 32'h1);
    // clock enable low must freeze filters and mapping and stall the bus
    ce <= 1'b0;
    level[8] <= 1'b0;
    repeat (40) @(posedge clk);
    check(32'(function_state[5]), 32'h1);
    check(32'({awready, wready, arready}), 32'h0);
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    check(32'(function_state[5]), 32'h0);
    // second reset in mid-run brings every register back to its reset value
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'({servo_on_request, forward_permit, reverse_permit}), 32'h0);
    check(function_state[31:0], 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'({reverse_permit, forward_permit}), 32'h3);
    expect_reg(32'h20, 32'h0);
    expect_reg(32'h04, 32'h2);
    expect_reg(32'h40, 32'h14);
    expect_reg(32'h84, 32'h0);
    // a single byte lane merges into the value already held
    wstrb <= 4'h2;
    set_reg(32'h40, 32'h00000300);
    wstrb <= 4'hF;
    expect_reg(32'h40, 32'h314);
    stop_test();
  end
endmodule
